// ---- src/tmr16_defs.svh ----
// register offsets, field positions, reset values and codes of the 16-bit timer control block
// assumes inclusion by bare name from the package and the design file
`ifndef TMR16_DEFS_SVH
`define TMR16_DEFS_SVH
`define TMR16_OFF_CTRL_A 8'h00
`define TMR16_OFF_CTRL_B 8'h01
`define TMR16_OFF_OUTVAL 8'h02
`define TMR16_OFF_SPLIT 8'h03
`define TMR16_OFF_CMD_CLR 8'h04
`define TMR16_OFF_CMD_SET 8'h05
`define TMR16_OFF_BV_CLR 8'h06
`define TMR16_OFF_BV_SET 8'h07
`define TMR16_OFF_CNT_L 8'h20
`define TMR16_OFF_CNT_H 8'h21
`define TMR16_OFF_PER_L 8'h26
`define TMR16_OFF_PER_H 8'h27
`define TMR16_OFF_CMP0_L 8'h28
`define TMR16_OFF_PERBUF_L 8'h36
`define TMR16_OFF_PERBUF_H 8'h37
`define TMR16_OFF_CMPBUF0_L 8'h38
`define TMR16_RESET_BYTE 8'h00
`define TMR16_EN_BIT 0
`define TMR16_PSC_LSB 1
`define TMR16_WGM_LSB 0
`define TMR16_ALU_BIT 3
`define TMR16_CEN_LSB 4
`define TMR16_CMD_LSB 2
`define TMR16_LOCK_UPDATE_BIT 1
`define TMR16_DIR_BIT 0
`define TMR16_SPLIT_BIT 0
`define TMR16_CMD_NONE 2'h0
`define TMR16_CMD_UPDATE 2'h1
`define TMR16_CMD_RESTART 2'h2
`define TMR16_CMD_HARDRST 2'h3
`define TMR16_PSC_MAX 10'h3FF
`endif

// ---- src/tmr16_pkg.sv ----
// types of the 16-bit timer control block
// assumes tmr16_defs.svh on the include path
`include "tmr16_defs.svh"
package tmr16_pkg;
  typedef enum logic [2:0] {
    TMR16_WG_NORMAL = 3'b000,
    TMR16_WG_FREQ = 3'b001,
    TMR16_WG_RSV2 = 3'b010,
    TMR16_WG_SINGLE = 3'b011,
    TMR16_WG_RSV4 = 3'b100,
    TMR16_WG_DS_TOP = 3'b101,
    TMR16_WG_DS_BOTH = 3'b110,
    TMR16_WG_DS_BOTTOM = 3'b111
  } tmr16_waveform_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr16_bus_req_t;

  typedef struct packed {
    logic [2:0] pin;
    logic [2:0] pin_en;
    logic [2:0] logic_blk;
  } tmr16_wave_t;

  typedef struct packed {
    logic enable;
    logic [2:0] prescale_select;
    logic [2:0] compare_output_enable;
    logic auto_lock_update;
    tmr16_waveform_mode_t waveform_mode;
    logic [2:0] compare_output_value;
    logic split_enable;
    logic lock_update;
    logic dir;
    logic period_buffer_valid;
    logic [2:0] compare_buffer_valid;
    logic [9:0] psc;
    logic [15:0] count;
    logic [15:0] top_value_reg;
    logic [15:0] period_buffer;
    logic [2:0][15:0] compare_value;
    logic [2:0][15:0] compare_buffer;
    logic [2:0] wave;
    logic update_pulse;
    logic ovf_pulse;
    logic [7:0] rdata;
    tmr16_wave_t wout;
  } tmr16_state_t;
endpackage

// ---- src/tmr16_ctrl.sv ----
// control part of a 16-bit timer/counter in normal (non-split) mode
// assumes a single 100 MHz clock, byte registers on a plain strobe port, same-clock master
// Function
// - prescale select bits 3:1 divide clock by 1,2,4,8,16,64,256,1024.
// - enable bit 0 runs the timer; zero keeps it disabled.
// - compare output enables bits 4..6 let channel waveforms override pins.
// - auto lock update holds lock until all enabled compare buffers valid.
// - after that, lock stays clear until next update, then sets again.
// - waveform mode field selects normal, frequency, single or dual ramp pwm.
// - update and overflow occur at top or bottom per waveform mode.
// - normal mode makes no waveform; others reach pins only when enabled.
// - while disabled, output value bits set waveform outputs directly.
// - forced values need pin enable at pads; logic block path ignores it.
// - split enable bit 0 is only stored and driven out on split_active; no split timers here.
// - clear registers at 0x04 and 0x06 clear bits written with one.
// - set register at 0x05 sets bits written with one.
// - command field acts on write: none, update, restart, hard reset; reads zero.
// - hard reset command is ignored while the timer is enabled.
// - lock update blocks buffer loads on update, not forced update.
// - without lock, buffers load at every update condition.
// - direction bit: zero up, one down; hardware and software may change it.
// - buffer valid bits set on buffer write, clear on update condition.
`timescale 1ns/100ps
`default_nettype none
`include "tmr16_defs.svh"
module tmr16_ctrl (
  input wire logic clock,
  input wire logic nrst,
  input wire tmr16_pkg::tmr16_bus_req_t bus,
  output logic [7:0] rdata,
  output tmr16_pkg::tmr16_wave_t wave_out,
  output logic split_active,
  output logic update_event,
  output logic overflow_event,
  output logic [15:0] count_value
);
  import tmr16_pkg::*;

  tmr16_state_t s_q;
  tmr16_state_t s_d;

  // terminal count per prescale code (divider minus one)
  function automatic logic [9:0] psc_limit(input logic [2:0] sel);
    case (sel)
      3'h0: psc_limit = 10'h000;
      3'h1: psc_limit = 10'h001;
      3'h2: psc_limit = 10'h003;
      3'h3: psc_limit = 10'h007;
      3'h4: psc_limit = 10'h00F;
      3'h5: psc_limit = 10'h03F;
      3'h6: psc_limit = 10'h0FF;
      default: psc_limit = `TMR16_PSC_MAX;
    endcase
  endfunction

  logic wr_hit;
  logic [7:0] wa;
  logic [7:0] wd;
  logic tick;
  logic [15:0] top;
  logic at_top;
  logic at_bot;
  logic upd_cond;
  logic do_load;
  logic forced_upd;
  logic restart;
  logic hard_rst;
  logic lock_next;
  logic all_valid;
  logic [2:0] cmp_match;
  logic [7:0] rd_mux;

  always_comb begin
    s_d = s_q;
    wr_hit = bus.wr;
    wa = bus.addr;
    wd = bus.wdata;
    forced_upd = 1'b0;
    restart = 1'b0;
    hard_rst = 1'b0;
    rd_mux = 8'h00;
    s_d.update_pulse = 1'b0;
    s_d.ovf_pulse = 1'b0;

    // command decode on a write to either command register
    if (wr_hit && (wa == `TMR16_OFF_CMD_CLR || wa == `TMR16_OFF_CMD_SET)) begin
      case (wd[`TMR16_CMD_LSB +: 2])
        `TMR16_CMD_UPDATE: forced_upd = 1'b1;
        `TMR16_CMD_RESTART: restart = 1'b1;
        `TMR16_CMD_HARDRST: hard_rst = !s_q.enable;
        default: forced_upd = 1'b0;
      endcase
    end

    // prescaler and counter
    tick = 1'b0;
    if (s_q.enable) begin
      if (s_q.psc >= psc_limit(s_q.prescale_select)) begin
        s_d.psc = 10'h000;
        tick = 1'b1;
      end else begin
        s_d.psc = s_q.psc + 10'h001;
      end
    end

    top = (s_q.waveform_mode == TMR16_WG_FREQ) ? s_q.compare_value[0] : s_q.top_value_reg;
    at_top = (s_q.count >= top);
    at_bot = (s_q.count == 16'h0000);
    upd_cond = 1'b0;
    if (tick) begin
      case (s_q.waveform_mode)
        TMR16_WG_NORMAL, TMR16_WG_FREQ, TMR16_WG_SINGLE: begin
          if (!s_q.dir) begin
            s_d.count = at_top ? 16'h0000 : s_q.count + 16'h0001;
          end else begin
            s_d.count = at_bot ? top : s_q.count - 16'h0001;
          end
          if (s_q.waveform_mode == TMR16_WG_SINGLE) begin
            upd_cond = at_bot;
            s_d.ovf_pulse = at_bot;
          end else begin
            upd_cond = at_top && !s_q.dir;
            s_d.ovf_pulse = at_top && !s_q.dir;
          end
        end
        TMR16_WG_DS_TOP, TMR16_WG_DS_BOTH, TMR16_WG_DS_BOTTOM: begin
          if (!s_q.dir && at_top) begin
            s_d.dir = 1'b1;
            s_d.count = s_q.count - 16'h0001;
          end else if (s_q.dir && at_bot) begin
            s_d.dir = 1'b0;
            s_d.count = s_q.count + 16'h0001;
          end else begin
            s_d.count = s_q.dir ? s_q.count - 16'h0001 : s_q.count + 16'h0001;
          end
          upd_cond = at_bot;
          case (s_q.waveform_mode)
            TMR16_WG_DS_TOP: s_d.ovf_pulse = at_top;
            TMR16_WG_DS_BOTH: s_d.ovf_pulse = at_top || at_bot;
            default: s_d.ovf_pulse = at_bot;
          endcase
        end
        default: upd_cond = 1'b0;
      endcase
    end
    s_d.update_pulse = upd_cond;

    // buffered loads
    do_load = forced_upd || (upd_cond && !s_q.lock_update);
    if (do_load) begin
      if (s_q.period_buffer_valid) s_d.top_value_reg = s_q.period_buffer;
    end
    if (upd_cond || forced_upd) begin
      s_d.period_buffer_valid = 1'b0;
      s_d.compare_buffer_valid = 3'b000;
    end

    // register writes; software dir clear wins over hardware dir set, auto lock set comes later and wins
    if (wr_hit) begin
      case (wa)
        `TMR16_OFF_CTRL_A: begin
          s_d.enable = wd[`TMR16_EN_BIT];
          s_d.prescale_select = wd[`TMR16_PSC_LSB +: 3];
        end
        `TMR16_OFF_CTRL_B: begin
          s_d.compare_output_enable = wd[`TMR16_CEN_LSB +: 3];
          s_d.auto_lock_update = wd[`TMR16_ALU_BIT];
          s_d.waveform_mode = tmr16_waveform_mode_t'(wd[`TMR16_WGM_LSB +: 3]);
        end
        `TMR16_OFF_OUTVAL: s_d.compare_output_value = wd[2:0];
        `TMR16_OFF_SPLIT: s_d.split_enable = wd[`TMR16_SPLIT_BIT];
        `TMR16_OFF_CMD_CLR: begin
          if (wd[`TMR16_LOCK_UPDATE_BIT]) s_d.lock_update = 1'b0;
          if (wd[`TMR16_DIR_BIT]) s_d.dir = 1'b0;
        end
        `TMR16_OFF_CMD_SET: begin
          if (wd[`TMR16_LOCK_UPDATE_BIT]) s_d.lock_update = 1'b1;
          if (wd[`TMR16_DIR_BIT]) s_d.dir = 1'b1;
        end
        `TMR16_OFF_BV_CLR: begin
          if (wd[0] && !(upd_cond || forced_upd)) s_d.period_buffer_valid = 1'b0;
          s_d.compare_buffer_valid = s_d.compare_buffer_valid & ~wd[3:1];
        end
        `TMR16_OFF_BV_SET: begin
          s_d.period_buffer_valid = s_d.period_buffer_valid | wd[0];
          s_d.compare_buffer_valid = s_d.compare_buffer_valid | wd[3:1];
        end
        `TMR16_OFF_CNT_L: s_d.count[7:0] = wd;
        `TMR16_OFF_CNT_H: s_d.count[15:8] = wd;
        `TMR16_OFF_PER_L: s_d.top_value_reg[7:0] = wd;
        `TMR16_OFF_PER_H: s_d.top_value_reg[15:8] = wd;
        `TMR16_OFF_PERBUF_L: begin
          s_d.period_buffer[7:0] = wd;
          s_d.period_buffer_valid = 1'b1;
        end
        `TMR16_OFF_PERBUF_H: begin
          s_d.period_buffer[15:8] = wd;
          s_d.period_buffer_valid = 1'b1;
        end
        default: s_d.split_enable = s_d.split_enable;
      endcase
    end

    // compare channels: direct and buffered access, loads and matches
    for (int i = 0; i < 3; i++) begin
      if (do_load && s_q.compare_buffer_valid[i]) s_d.compare_value[i] = s_q.compare_buffer[i];
      if (wr_hit && wa == `TMR16_OFF_CMP0_L + 8'(2 * i)) s_d.compare_value[i][7:0] = wd;
      if (wr_hit && wa == `TMR16_OFF_CMP0_L + 8'(2 * i + 1)) s_d.compare_value[i][15:8] = wd;
      if (wr_hit && (wa == `TMR16_OFF_CMPBUF0_L + 8'(2 * i)
          || wa == `TMR16_OFF_CMPBUF0_L + 8'(2 * i + 1))) begin
        if (wa[0]) s_d.compare_buffer[i][15:8] = wd;
        else s_d.compare_buffer[i][7:0] = wd;
        s_d.compare_buffer_valid[i] = 1'b1;
      end
      cmp_match[i] = (s_q.count == s_q.compare_value[i]);
    end

    // auto lock update
    all_valid = ((s_d.compare_buffer_valid & s_q.compare_output_enable)
                 == s_q.compare_output_enable);
    lock_next = s_d.lock_update;
    if (s_q.auto_lock_update) begin
      if (upd_cond || forced_upd) lock_next = 1'b1;
      else if (s_q.lock_update && all_valid) lock_next = 1'b0;
    end
    if (wr_hit && wa == `TMR16_OFF_CTRL_B && wd[`TMR16_ALU_BIT] && !s_q.auto_lock_update) begin
      lock_next = 1'b1;
    end
    s_d.lock_update = lock_next;

    // waveform generator
    if (!s_q.enable) begin
      s_d.wave = s_d.compare_output_value;
    end else if (tick) begin
      for (int i = 0; i < 3; i++) begin
        case (s_q.waveform_mode)
          TMR16_WG_FREQ: if (cmp_match[0] && i == 0) s_d.wave[i] = !s_q.wave[i];
          TMR16_WG_SINGLE: s_d.wave[i] = (s_d.count < s_q.compare_value[i]);
          TMR16_WG_DS_TOP, TMR16_WG_DS_BOTH, TMR16_WG_DS_BOTTOM:
            s_d.wave[i] = (s_d.count < s_q.compare_value[i]);
          default: s_d.wave[i] = s_q.wave[i];
        endcase
      end
    end
    if (restart) begin
      s_d.count = 16'h0000;
      s_d.dir = 1'b0;
      s_d.psc = 10'h000;
      s_d.wave = 3'b000;
    end
    if (hard_rst) begin
      s_d.count = 16'h0000;
      s_d.dir = 1'b0;
      s_d.psc = 10'h000;
      s_d.top_value_reg = 16'hFFFF;
      s_d.compare_value = '0;
      s_d.wave = 3'b000;
    end

    // outputs
    s_d.wout.logic_blk = s_d.wave;
    if (s_d.waveform_mode == TMR16_WG_NORMAL && s_d.enable) begin
      s_d.wout.pin_en = 3'b111;
      s_d.wout.pin = 3'b000;
    end else begin
      s_d.wout.pin_en = ~s_d.compare_output_enable;
      s_d.wout.pin = s_d.wave & s_d.compare_output_enable;
    end

    // read data for next cycle
    case (bus.addr)
      `TMR16_OFF_CTRL_A: rd_mux = {4'h0, s_q.prescale_select, s_q.enable};
      `TMR16_OFF_CTRL_B: rd_mux = {1'b0, s_q.compare_output_enable, s_q.auto_lock_update,
                                   3'(s_q.waveform_mode)};
      `TMR16_OFF_OUTVAL: rd_mux = {5'h00, s_q.compare_output_value};
      `TMR16_OFF_SPLIT: rd_mux = {7'h00, s_q.split_enable};
      `TMR16_OFF_CMD_CLR, `TMR16_OFF_CMD_SET: rd_mux = {6'h00, s_q.lock_update, s_q.dir};
      `TMR16_OFF_BV_CLR, `TMR16_OFF_BV_SET:
        rd_mux = {4'h0, s_q.compare_buffer_valid, s_q.period_buffer_valid};
      `TMR16_OFF_CNT_L: rd_mux = s_q.count[7:0];
      `TMR16_OFF_CNT_H: rd_mux = s_q.count[15:8];
      `TMR16_OFF_PER_L: rd_mux = s_q.top_value_reg[7:0];
      `TMR16_OFF_PER_H: rd_mux = s_q.top_value_reg[15:8];
      default: rd_mux = 8'h00;
    endcase
    s_d.rdata = bus.rd ? rd_mux : 8'h00;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.top_value_reg <= 16'hFFFF;
      s_q.wout.pin_en <= 3'b111;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign wave_out = s_q.wout;
  assign split_active = s_q.split_enable;
  assign update_event = s_q.update_pulse;
  assign overflow_event = s_q.ovf_pulse;
  assign count_value = s_q.count;
endmodule
`default_nettype wire

// ---- dv/tmr16_ctrl_monitor.sv ----
// checker of the 16-bit timer control block, bound to its top module
// assumes one clock domain; control fields are shadowed from bus writes
`timescale 1ns/100ps
`default_nettype none
module tmr16_ctrl_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire tmr16_pkg::tmr16_bus_req_t bus,
  input wire logic [7:0] rdata,
  input wire tmr16_pkg::tmr16_wave_t wave_out,
  input wire logic split_active,
  input wire logic update_event,
  input wire logic overflow_event,
  input wire logic [15:0] count_value
);
  import tmr16_pkg::*;
  logic en_s;
  logic split_s;
  logic [2:0] psc_s;
  logic [2:0] wgm_s;
  logic [2:0] cen_s;
  logic [2:0] ov_s;
  logic [2:0] wr_h;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_s <= 1'b0;
      split_s <= 1'b0;
      psc_s <= 3'h0;
      wgm_s <= 3'h0;
      cen_s <= 3'h0;
      ov_s <= 3'h0;
      wr_h <= 3'h0;
    end else begin
      wr_h <= {wr_h[1:0], bus.wr};
      if (bus.wr && bus.addr == 8'h00) begin
        en_s <= bus.wdata[0];
        psc_s <= bus.wdata[3:1];
      end
      if (bus.wr && bus.addr == 8'h01) begin
        wgm_s <= bus.wdata[2:0];
        cen_s <= bus.wdata[6:4];
      end
      if (bus.wr && bus.addr == 8'h02) begin
        ov_s <= bus.wdata[2:0];
      end
      if (bus.wr && bus.addr == 8'h03) begin
        split_s <= bus.wdata[0];
      end
    end
  end
  chk_cmd_reads_zero: assert property (
    $past(bus.rd) && ($past(bus.addr) inside {8'h04, 8'h05}) |-> rdata[3:2] == 2'h0)
    else $error("command field read back non-zero");
  chk_count_hold: assert property (
    !en_s && wr_h == 3'h0 |-> $stable(count_value))
    else $error("counter moved while disabled");
  chk_count_step: assert property (
    en_s && wr_h == 3'h0 && $changed(count_value) |->
    count_value == $past(count_value) + 16'h1 || count_value == $past(count_value) - 16'h1
    || count_value == 16'h0)
    else $error("counter jumped by more than one");
  chk_prescale_gap: assert property (
    en_s && psc_s != 3'h0 && wr_h == 3'h0 && !bus.wr && $changed(count_value)
    |=> $stable(count_value))
    else $error("divided counter stepped on two clocks in a row");
  chk_ovf_with_upd: assert property (
    en_s && wr_h == 3'h0 && (wgm_s inside {3'h0, 3'h1, 3'h3, 3'h7})
    |-> overflow_event == update_event)
    else $error("overflow and update apart in a mode where they coincide");
  chk_pad_masked: assert property (
    (wave_out.pin & wave_out.pin_en) == 3'h0)
    else $error("pad value on an undriven channel");
  chk_pad_enable: assert property (
    !en_s && wr_h == 3'h0 |-> wave_out.pin_en == ~cen_s)
    else $error("pad enable differs from compare output enables");
  chk_forced_value: assert property (
    bus.wr && bus.addr == 8'h02 && !en_s |-> ##[1:3] wave_out.logic_blk == ov_s)
    else $error("forced output value not applied");
  chk_split_out: assert property (
    bus.wr && bus.addr == 8'h03 |-> ##[1:2] split_active == split_s)
    else $error("split output differs from written bit");
endmodule
bind tmr16_ctrl tmr16_ctrl_monitor mon (.clock(clock), .nrst(nrst), .bus(bus),
  .rdata(rdata), .wave_out(wave_out), .split_active(split_active),
  .update_event(update_event), .overflow_event(overflow_event), .count_value(count_value));
`default_nettype wire

// ---- dv/tmr16_ctrl_bench.sv ----
// self-checking bench of the 16-bit timer control block
// assumes the checker file is compiled with it and binds itself
`timescale 1ns/100ps
`default_nettype none
module tmr16_ctrl_bench;
  import tmr16_pkg::*;
  logic clock;
  logic nrst;
  tmr16_bus_req_t bus;
  logic [7:0] rdata;
  tmr16_wave_t wave_out;
  logic split_active;
  logic update_event;
  logic overflow_event;
  logic [15:0] count_value;
  int err_count;
  int compares;
  logic pend = 1'b0;
  logic [7:0] note_q[$];
  logic [7:0] d;
  logic [15:0] c0;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  int divs [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  tmr16_ctrl uut (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata),
    .wave_out(wave_out), .split_active(split_active), .update_event(update_event),
    .overflow_event(overflow_event), .count_value(count_value));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic compare(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      err_count++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic stop_test;
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    note_q.push_back(want);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clock);
  endtask
  // read data stand in the cycle after the strobe
  always @(posedge clock) begin
    if (pend) begin
      compare({8'h00, rdata}, {8'h00, note_q.pop_front()});
    end
    pend <= bus.rd;
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    stop_test();
  end
  initial begin
    bus = '0;
    nrst = 1'b0;
    err_count = 0;
    compares = 0;
    void'($urandom(32'hD551));
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int a = 0; a < 8; a++) begin
      rd(8'(a), 8'h00);
    end
    rd(8'h10, 8'h00);
    // pad directions are taken as outputs in the port block
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      wr(8'h00, d & 8'h0E);
      wr(8'h01, {1'b0, d[6:4], 1'b0, modes[i]});
      wr(8'h02, d & 8'h07);
      wr(8'h03, d & 8'h01);
      rd(8'h00, d & 8'h0E);
      rd(8'h01, {1'b0, d[6:4], 1'b0, modes[i]});
      rd(8'h02, d & 8'h07);
      rd(8'h03, d & 8'h01);
      idle(3);
      compare({13'h0, wave_out.pin}, {13'h0, d[2:0] & d[6:4]});
      compare({13'h0, wave_out.logic_blk}, {13'h0, d[2:0]});
    end
    wr(8'h26, 8'h08);
    wr(8'h27, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(8'h01, {5'h00, modes[i]});
      wr(8'h00, 8'h01);
      idle(40);
      wr(8'h00, 8'h00);
      wr(8'h05, 8'h08);
      rd(8'h04, 8'h00);
      rd(8'h20, 8'h00);
    end
    wr(8'h01, 8'h00);
    wr(8'h05, 8'h03);
    rd(8'h04, 8'h03);
    wr(8'h04, 8'h01);
    rd(8'h05, 8'h02);
    wr(8'h04, 8'h02);
    rd(8'h04, 8'h00);
    wr(8'h36, 8'h10);
    wr(8'h37, 8'h00);
    wr(8'h38, 8'h22);
    rd(8'h06, 8'h03);
    wr(8'h06, 8'h02);
    rd(8'h06, 8'h01);
    wr(8'h05, 8'h02);
    wr(8'h05, 8'h04);
    rd(8'h06, 8'h00);
    rd(8'h26, 8'h10);
    wr(8'h04, 8'h02);
    wr(8'h36, 8'h05);
    wr(8'h37, 8'h00);
    wr(8'h00, 8'h01);
    idle(60);
    wr(8'h00, 8'h00);
    rd(8'h26, 8'h05);
    rd(8'h06, 8'h00);
    wr(8'h01, 8'h18);
    rd(8'h04, 8'h02);
    wr(8'h38, 8'h02);
    wr(8'h39, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h00, 8'h01);
    idle(20);
    wr(8'h00, 8'h00);
    rd(8'h04, 8'h02);
    wr(8'h01, 8'h00);
    wr(8'h04, 8'h02);
    wr(8'h00, 8'h01);
    wr(8'h05, 8'h0C);
    rd(8'h26, 8'h05);
    wr(8'h00, 8'h00);
    wr(8'h05, 8'h0C);
    rd(8'h27, 8'hFF);
    rd(8'h20, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, {4'h0, 3'(k), 1'b1});
      idle(3);
      c0 = count_value;
      repeat (4 * divs[k]) @(posedge clock);
      compare(count_value - c0, 16'h0004);
      wr(8'h00, 8'h00);
    end
    idle(3);
    stop_test();
  end
endmodule
`default_nettype wire
